/* File: rtl/stm_timer.sv */
/*
 * Standard 16-bit timer channel with compare, pwm, single pulse and capture.
 * Assumes a classic Wishbone master on I_MCLK; the capture pin is asynchronous.
 * The timer counts on every I_MCLK edge where I_TCLK_EN is high while counter_on is set and counter_pause is clear, except the edge after counter_on rises.
 */
`timescale 1ns/100ps
module stm_timer (
	input  wire logic        I_MCLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_TCLK_EN,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	input  wire logic        I_CAPTURE_INPUT_PIN,
	output logic             O_TIMER_OUTPUT_PIN,
	output logic             O_TIMER_OUTPUT_OE
);
	// registers
	logic [7:0]          ctrl0_ff, nxt_ctrl0;
	stm_pkg::stm_ctrl1_s ctrl1_ff, nxt_ctrl1;
	logic [15:0]         cmpa_ff, nxt_cmpa;
	logic [7:0]          pcmp_ff, nxt_pcmp;
	logic [2:0]          stat_ff, nxt_stat;
	logic [15:0]         cap_ff, nxt_cap;
	logic [15:0]         cnt_ff, nxt_cnt;
	logic                pin_ff, nxt_pin;
	logic                on_d_ff, nxt_on_d;
	logic                ack_ff, nxt_ack;
	logic [31:0]         rdat_ff, nxt_rdat;
	logic                sy1_ff, sy2_ff, sy3_ff;

	logic                on, pause, bus_req, wr;
	logic                on_rise, tick;
	stm_pkg::stm_match_s m;
	logic                clr_cnt, pwm_act, raw_out;
	logic [15:0]         cnt_inc;
	logic                cap_rise, cap_fall, cap_hit, drive_en, nxt_out_pin;

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] d,
					     input logic sel);
		merge8 = sel ? d : old;
	endfunction

	assign on      = ctrl0_ff[stm_pkg::CTRL0_ON_BIT];
	assign pause   = ctrl0_ff[stm_pkg::CTRL0_PAU_BIT];
	assign bus_req = I_WB_CYC & I_WB_STB & ~ack_ff;
	// writes land at the edge that samples ack, as a classic master expects
	assign wr      = I_WB_CYC & I_WB_STB & I_WB_WE & ack_ff;
	assign on_rise = on & ~on_d_ff;
	assign tick    = on & ~on_rise & ~pause & I_TCLK_EN;

	assign cnt_inc = cnt_ff + 16'h0001;

	// comparators
	always_comb begin
		m.a_match = tick & (cnt_ff == cmpa_ff);
		// P sees the upper byte about to be reached, so the period is exactly P*256
		m.p_match = tick & (pcmp_ff != 8'h00) & (cnt_inc[15:8] == pcmp_ff)
			    & (cnt_inc[7:0] == 8'h00);
		m.ovf     = tick & (cnt_ff == 16'hffff) & (pcmp_ff == 8'h00);
	end

	// counter clear source per mode
	always_comb begin
		clr_cnt = 1'b0;
		case (ctrl1_ff.mode_select)
		stm_pkg::STM_MODE_CMP, stm_pkg::STM_MODE_TMR: begin
			if (ctrl1_ff.clear_source_select)
				clr_cnt = m.a_match;
			else
				clr_cnt = m.p_match | m.ovf;
		end
		stm_pkg::STM_MODE_PWM: begin
			// period comparator ignores clear source select
			if (ctrl1_ff.duty_period_swap)
				clr_cnt = m.a_match;
			else
				clr_cnt = m.p_match | m.ovf;
		end
		default: clr_cnt = 1'b0;
		endcase
	end

	// capture edge select from synchronised pin
	always_comb begin
		cap_rise = sy2_ff & ~sy3_ff;
		cap_fall = ~sy2_ff & sy3_ff;
		case (ctrl1_ff.pin_function_select)
		2'b00:   cap_hit = cap_rise;
		2'b01:   cap_hit = cap_fall;
		2'b10:   cap_hit = cap_rise | cap_fall;
		default: cap_hit = 1'b0;
		endcase
	end

	// pwm active phase: duty comparator against counter
	always_comb begin
		if (ctrl1_ff.duty_period_swap)
			pwm_act = (pcmp_ff == 8'h00) ? 1'b1 : (cnt_ff[15:8] < pcmp_ff);
		else
			pwm_act = cnt_ff < cmpa_ff;
	end

	// counter, pin, flags, control
	always_comb begin
		nxt_cnt   = cnt_ff;
		nxt_pin   = pin_ff;
		nxt_on_d  = on;
		nxt_stat  = stat_ff;
		nxt_cap   = cap_ff;
		nxt_ctrl0 = ctrl0_ff;
		nxt_ctrl1 = ctrl1_ff;
		nxt_cmpa  = cmpa_ff;
		nxt_pcmp  = pcmp_ff;

		if (on_rise)
			nxt_cnt = 16'h0000;
		else if (clr_cnt)
			nxt_cnt = 16'h0000;
		else if (tick)
			nxt_cnt = cnt_inc;

		// pin follows initial level at on rise, A matches in compare mode
		if (on_rise)
			nxt_pin = ctrl1_ff.output_initial_level;
		else if (ctrl1_ff.mode_select == stm_pkg::STM_MODE_CMP && m.a_match) begin
			case (ctrl1_ff.pin_function_select)
			2'b00:   nxt_pin = pin_ff;
			2'b01:   nxt_pin = 1'b0;
			2'b10:   nxt_pin = 1'b1;
			default: nxt_pin = ~pin_ff;
			endcase
		end

		// write-1-to-clear below; hardware set applied after so set wins
		if (wr && I_WB_ADR == stm_pkg::ADDR_STATUS && I_WB_SEL[0])
			nxt_stat = stat_ff & ~I_WB_DAT[2:0];
		if (ctrl1_ff.mode_select != stm_pkg::STM_MODE_CAP) begin
			if (m.a_match)
				nxt_stat[stm_pkg::STAT_AF_BIT] = 1'b1;
			if ((m.p_match | m.ovf) && !(ctrl1_ff.clear_source_select
			    && ctrl1_ff.mode_select != stm_pkg::STM_MODE_PWM))
				nxt_stat[stm_pkg::STAT_PF_BIT] = 1'b1;
		end

		// capture edges from synchronised pin
		if (ctrl1_ff.mode_select == stm_pkg::STM_MODE_CAP && on) begin
			if (cap_hit) begin
				nxt_cap = cnt_ff;
				nxt_stat[stm_pkg::STAT_CF_BIT] = 1'b1;
			end
		end

		if (wr) begin
			case (I_WB_ADR)
			stm_pkg::ADDR_CTRL0:
				nxt_ctrl0 = merge8(ctrl0_ff, {I_WB_DAT[7:3], 3'b000}, I_WB_SEL[0]);
			stm_pkg::ADDR_CTRL1:
				nxt_ctrl1 = merge8(ctrl1_ff, I_WB_DAT[7:0], I_WB_SEL[0]);
			stm_pkg::ADDR_CMPA: begin
				nxt_cmpa[7:0]  = merge8(cmpa_ff[7:0], I_WB_DAT[7:0], I_WB_SEL[0]);
				nxt_cmpa[15:8] = merge8(cmpa_ff[15:8], I_WB_DAT[15:8], I_WB_SEL[1]);
			end
			stm_pkg::ADDR_PCMP:
				nxt_pcmp = merge8(pcmp_ff, I_WB_DAT[7:0], I_WB_SEL[0]);
			default: ;
			endcase
		end

		// single pulse: A match ends the pulse by switching off
		if (ctrl1_ff.mode_select == stm_pkg::STM_MODE_PWM
		    && ctrl1_ff.pin_function_select == 2'b11 && m.a_match)
			nxt_ctrl0[stm_pkg::CTRL0_ON_BIT] = 1'b0;
	end

	// bus answer: one cycle after request, dropped next cycle
	always_comb begin
		nxt_ack  = bus_req;
		nxt_rdat = 32'h0000_0000;
		case (I_WB_ADR)
		stm_pkg::ADDR_CTRL0:   nxt_rdat[7:0]  = ctrl0_ff;
		stm_pkg::ADDR_CTRL1:   nxt_rdat[7:0]  = ctrl1_ff;
		stm_pkg::ADDR_CNT:     nxt_rdat[15:0] = cnt_ff;
		stm_pkg::ADDR_CMPA:    nxt_rdat[15:0] = cmpa_ff;
		stm_pkg::ADDR_PCMP:    nxt_rdat[7:0]  = pcmp_ff;
		stm_pkg::ADDR_STATUS:  nxt_rdat[2:0]  = stat_ff;
		stm_pkg::ADDR_CAPTURE: nxt_rdat[15:0] = cap_ff;
		default:               nxt_rdat = 32'h0000_0000;
		endcase
	end

	// output level per mode
	always_comb begin
		raw_out = 1'b0;
		case (ctrl1_ff.mode_select)
		stm_pkg::STM_MODE_CMP: raw_out = pin_ff;
		stm_pkg::STM_MODE_PWM: begin
			case (ctrl1_ff.pin_function_select)
			2'b00:   raw_out = ~ctrl1_ff.output_initial_level;
			2'b01:   raw_out = ctrl1_ff.output_initial_level;
			2'b10:   raw_out = on & pwm_act ? ctrl1_ff.output_initial_level
						  : ~ctrl1_ff.output_initial_level;
			default: raw_out = on ? ctrl1_ff.output_initial_level
				      : ~ctrl1_ff.output_initial_level;
			endcase
		end
		default: raw_out = 1'b0;
		endcase
	end

	// pin released in timer/counter and capture modes; invert must not leak there
	assign drive_en    = (ctrl1_ff.mode_select == stm_pkg::STM_MODE_CMP)
			   | (ctrl1_ff.mode_select == stm_pkg::STM_MODE_PWM);
	assign nxt_out_pin = raw_out ^ (ctrl1_ff.output_invert & drive_en);

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			ctrl0_ff <= stm_pkg::RST_CTRL0;
			ctrl1_ff <= stm_pkg::RST_CTRL1;
			cmpa_ff  <= stm_pkg::RST_CMPA;
			pcmp_ff  <= stm_pkg::RST_PCMP;
			stat_ff  <= 3'h0;
			cap_ff   <= 16'h0000;
			cnt_ff   <= 16'h0000;
			pin_ff   <= 1'b0;
			on_d_ff  <= 1'b0;
			ack_ff   <= 1'b0;
			rdat_ff  <= 32'h0000_0000;
			sy1_ff   <= 1'b0;
			sy2_ff   <= 1'b0;
			sy3_ff   <= 1'b0;
			O_TIMER_OUTPUT_PIN <= 1'b0;
			O_TIMER_OUTPUT_OE  <= 1'b0;
		end else begin
			ctrl0_ff <= nxt_ctrl0;
			ctrl1_ff <= nxt_ctrl1;
			cmpa_ff  <= nxt_cmpa;
			pcmp_ff  <= nxt_pcmp;
			stat_ff  <= nxt_stat;
			cap_ff   <= nxt_cap;
			cnt_ff   <= nxt_cnt;
			pin_ff   <= nxt_pin;
			on_d_ff  <= nxt_on_d;
			ack_ff   <= nxt_ack;
			rdat_ff  <= nxt_rdat;
			sy1_ff   <= I_CAPTURE_INPUT_PIN;
			sy2_ff   <= sy1_ff;
			sy3_ff   <= sy2_ff;
			O_TIMER_OUTPUT_PIN <= nxt_out_pin;
			O_TIMER_OUTPUT_OE  <= drive_en;
		end
	end

	assign O_WB_ACK = ack_ff;
	assign O_WB_DAT = rdat_ff;
endmodule

/* File: rtl/stm_pkg.sv */
/*
 * Constants, register map and carrier types for the standard timer channel.
 * Assumes a classic Wishbone slave with 32-bit data, one register per word.
 */
// Overview of operation
// - compare mode: A match leaves, lowers, raises or toggles pin per select 00..11
// - pwm mode: select forces inactive, active, pwm waveform, or single pulse
// - capture mode: select picks rising, falling, both edges, or none
// - timer/counter mode ignores select, initial level and invert
// - requested level equal to initial level gives no visible pin change
// - counter_on rising returns the compare mode pin to its initial level
// - compare mode: initial level 0 starts pin low, 1 high
// - pwm mode: initial level chooses active low (0) or active high (1)
// - output_invert 1 inverts the pin level, 0 passes it
// - swap 0: P sets period, A duty; swap 1: P duty, A period
// - clear source 1 clears on A match; 0 on P match or overflow
// - overflow clearing applies only when compare_p_value is zero
// - clear source ignored in pwm, single pulse and capture modes
// - P compares counter bits 15..8; 0 gives 65536 clocks, N gives N*256
// - mode 00 is compare match output, cleared by overflow, A or P
// - compare mode, clear source 0: A and P flags both raised
// - compare mode, clear source 1: only A flag raised
// - only A matches and counter_on rises change the pin in compare mode
// - mode 00 compare, 01 capture, 10 pwm/pulse, 11 timer/counter
// - counter_on rise zeroes counter; fall stops and holds the count
// - 16-bit up counter; comparator A checks all 16 bits
// - counter_pause 1 holds the count, 0 resumes from it
package stm_pkg;
	localparam logic [7:0] ADDR_CTRL0    = 8'h00;
	localparam logic [7:0] ADDR_CTRL1    = 8'h04;
	localparam logic [7:0] ADDR_CNT      = 8'h08;
	localparam logic [7:0] ADDR_CMPA     = 8'h0c;
	localparam logic [7:0] ADDR_PCMP     = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_CAPTURE  = 8'h18;
	localparam logic [7:0] RST_CTRL0     = 8'h00;
	localparam logic [7:0] RST_CTRL1     = 8'h00;
	localparam logic [15:0] RST_CMPA     = 16'h0000;
	localparam logic [7:0] RST_PCMP      = 8'h00;
	localparam int          CTRL0_ON_BIT  = 3;
	localparam int          CTRL0_PAU_BIT = 7;
	localparam int          STAT_AF_BIT   = 0;
	localparam int          STAT_PF_BIT   = 1;
	localparam int          STAT_CF_BIT   = 2;

	typedef enum logic [1:0] {
		STM_MODE_CMP = 2'b00,
		STM_MODE_CAP = 2'b01,
		STM_MODE_PWM = 2'b10,
		STM_MODE_TMR = 2'b11
	} stm_mode_e;

	typedef struct packed {
		stm_mode_e  mode_select;
		logic [1:0] pin_function_select;
		logic       output_initial_level;
		logic       output_invert;
		logic       duty_period_swap;
		logic       clear_source_select;
	} stm_ctrl1_s;

	typedef struct packed {
		logic a_match;
		logic p_match;
		logic ovf;
	} stm_match_s;
endpackage

/* File: verification/stm_timer_asserts.sv */
/* checker for pin levels and bus timing of the timer channel
   assumes it is bound to the timer top, writes land at the edge sampling ack */
`timescale 1ns/100ps
module stm_timer_asserts (
	input wire logic	I_MCLK,
	input wire logic	I_RESETN,
	input wire logic	I_WB_CYC,
	input wire logic	I_WB_STB,
	input wire logic	I_WB_WE,
	input wire logic [7:0]	I_WB_ADR,
	input wire logic [3:0]	I_WB_SEL,
	input wire logic [31:0]	I_WB_DAT,
	input wire logic	O_WB_ACK,
	input wire logic	O_TIMER_OUTPUT_PIN,
	input wire logic	O_TIMER_OUTPUT_OE
);
	logic [7:0]	c1_ff, nxt_c1;
	logic		on_ff, nxt_on, wr;
	logic [1:0]	q_ff, nxt_q;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);
	// q counts quiet cycles: pin lags control by two registers
	always_comb begin
		wr = I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0] && O_WB_ACK;
		nxt_c1 = (wr && I_WB_ADR == stm_pkg::ADDR_CTRL1) ? I_WB_DAT[7:0] : c1_ff;
		nxt_on = (wr && I_WB_ADR == stm_pkg::ADDR_CTRL0) ? I_WB_DAT[3] : on_ff;
		nxt_q = (wr && I_WB_ADR <= stm_pkg::ADDR_CTRL1) ? 2'h0 : q_ff + {1'b0, q_ff != 2'h3};
		if (!I_RESETN) begin
			nxt_c1 = 8'h00;
			nxt_on = 1'b0;
			nxt_q = 2'h0;
		end
	end
	always_ff @(posedge I_MCLK) begin
		c1_ff <= nxt_c1;
		on_ff <= nxt_on;
		q_ff <= nxt_q;
	end
	a_oe_compare: assert property (c1_ff[7:6] == 2'b00 && q_ff == 2'h3 |-> O_TIMER_OUTPUT_OE)
		else $error("output enable low in compare mode");
	a_oe_timer: assert property (c1_ff[7:6] == 2'b11 && q_ff == 2'h3 |-> !O_TIMER_OUTPUT_OE)
		else $error("output enable high in timer mode");
	a_pwm_inactive: assert property (c1_ff[7:4] == 4'h8 && q_ff == 2'h3 |-> O_TIMER_OUTPUT_PIN == (!c1_ff[3] ^ c1_ff[2]))
		else $error("forced inactive level wrong");
	a_pwm_active: assert property (c1_ff[7:4] == 4'h9 && q_ff == 2'h3 |-> O_TIMER_OUTPUT_PIN == (c1_ff[3] ^ c1_ff[2]))
		else $error("forced active level wrong");
	a_cmp_hold: assert property (c1_ff[7:4] == 4'h0 && q_ff == 2'h3 |=> $stable(O_TIMER_OUTPUT_PIN))
		else $error("pin moved with no-change select");
	a_on_initial: assert property ($rose(on_ff) && c1_ff[7:6] == 2'b00 |-> ##[1:3] O_TIMER_OUTPUT_PIN == (c1_ff[3] ^ c1_ff[2]))
		else $error("pin not at initial level after start");
	a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
		else $error("no ack one cycle after request");
	c_pwm_high: cover property (c1_ff[7:6] == 2'b10 && O_TIMER_OUTPUT_PIN);
	c_start: cover property ($rose(on_ff));
	c_read: cover property (O_WB_ACK && !I_WB_WE);
endmodule
bind stm_timer stm_timer_asserts u_chk (.I_MCLK, .I_RESETN, .I_WB_CYC, .I_WB_STB, .I_WB_WE,
	.I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_ACK, .O_TIMER_OUTPUT_PIN, .O_TIMER_OUTPUT_OE);

/* File: verification/stm_pin_partner.sv */
/* outside circuit: drives the capture pin, counts output rises
   assumes the bench asks for capture edges by level */
`timescale 1ns/100ps
module stm_pin_partner (
	input  wire logic	i_clk,
	input  wire logic	i_want,
	input  wire logic	i_pin,
	input  wire logic	i_oe,
	output logic		o_cap,
	output logic [15:0]	o_edges
);
	logic last = 1'b0;
	initial o_cap = 1'b0;
	initial o_edges = 16'h0000;
	// an outside source is not tied to the timer clock
	always @(negedge i_clk) o_cap <= i_want;
	always @(posedge i_clk) begin
		if (i_oe && i_pin && !last) o_edges <= o_edges + 16'h0001;
		last <= i_pin;
	end
endmodule

/* File: verification/standard_timer_compare_output_tb_top.sv */
/* bench for the timer channel: bus tasks, read queue, pin checks
   assumes the checker is bound to the design */
`timescale 1ns/100ps
module standard_timer_compare_output_tb_top;
	logic		clk = 1'b0, rstn = 1'b0, ten = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, want = 1'b0;
	logic [7:0]	adr = 8'h00;
	logic [3:0]	sel = 4'h0;
	logic [31:0]	wdat = 32'h0, rdat, r, exp_q[$];
	logic		ack, pin, oe, cap;
	logic [15:0]	edges, e0;
	int		failures = 0, compares = 0, seed = 63;
	always #2.5 clk = ~clk;
	stm_timer DUT (.I_MCLK(clk), .I_RESETN(rstn), .I_TCLK_EN(ten), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
		.O_WB_ACK(ack), .I_CAPTURE_INPUT_PIN(cap), .O_TIMER_OUTPUT_PIN(pin), .O_TIMER_OUTPUT_OE(oe));
	stm_pin_partner u_far (.i_clk(clk), .i_want(want), .i_pin(pin), .i_oe(oe), .o_cap(cap),
		.o_edges(edges));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h3;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			ten <= 1'b1;
			@(posedge clk);
			ten <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (ack && !we) chk(rdat, exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(stm_pkg::ADDR_PCMP, 32'h0);
		rd(8'h40, 32'h0);
		r = $random(seed);
		wb(1'b1, stm_pkg::ADDR_PCMP, r);
		rd(stm_pkg::ADDR_PCMP, {24'h0, r[7:0]});
		wb(1'b1, stm_pkg::ADDR_CMPA, r);
		rd(stm_pkg::ADDR_CMPA, {16'h0, r[15:0]});
		wb(1'b1, stm_pkg::ADDR_CMPA, 32'hffff);
		wb(1'b1, stm_pkg::ADDR_CTRL1, 32'hc4);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
		rd(stm_pkg::ADDR_CNT, 32'h0);
		tick(5);
		rd(stm_pkg::ADDR_CNT, 32'h5);
		chk({30'h0, oe, pin}, 32'h0);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h88);
		tick(3);
		rd(stm_pkg::ADDR_CNT, 32'h5);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
		tick(2);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
		tick(3);
		rd(stm_pkg::ADDR_CNT, 32'h7);
		ten <= 1'b1;
		wb(1'b1, stm_pkg::ADDR_CMPA, 32'h14);
		wb(1'b1, stm_pkg::ADDR_PCMP, 32'h01);
		for (int c = 1; c >= 0; c--) begin
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
			wb(1'b1, stm_pkg::ADDR_STATUS, 32'h07);
			rd(stm_pkg::ADDR_STATUS, 32'h0);
			wb(1'b1, stm_pkg::ADDR_CTRL1, {31'h0c, c[0]});
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
			repeat (600) @(posedge clk);
			rd(stm_pkg::ADDR_STATUS, {30'h0, !c[0], 1'b1});
		end
		chk({31'h0, edges != 16'h0}, 32'h1);
		wb(1'b1, stm_pkg::ADDR_CMPA, 32'hffff);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
			wb(1'b1, stm_pkg::ADDR_CTRL1, {28'h0, i[0], i[1], 2'b00});
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
			repeat (3) @(posedge clk);
			chk({31'h0, pin}, {31'h0, i[0] ^ i[1]});
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
			for (int s = 0; s < 2; s++) begin
				wb(1'b1, stm_pkg::ADDR_CTRL1, {24'h0, 2'b10, s[1:0], i[0], i[1], 2'b00});
				repeat (3) @(posedge clk);
				chk({30'h0, oe, pin}, {31'h1, (i[0] ~^ s[0]) ^ i[1]});
			end
		end
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
		wb(1'b1, stm_pkg::ADDR_CMPA, 32'h40);
		wb(1'b1, stm_pkg::ADDR_CTRL1, 32'ha8);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
		repeat (300) @(posedge clk);
		e0 = edges;
		repeat (512) @(posedge clk);
		chk({16'h0, edges - e0}, 32'h2);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
		wb(1'b1, stm_pkg::ADDR_CMPA, 32'h20);
		wb(1'b1, stm_pkg::ADDR_CTRL1, 32'hb8);
		wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
		repeat (3) @(posedge clk);
		chk({31'h0, pin}, 32'h1);
		repeat (60) @(posedge clk);
		chk({31'h0, pin}, 32'h0);
		rd(stm_pkg::ADDR_CTRL0, 32'h0);
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h00);
			wb(1'b1, stm_pkg::ADDR_STATUS, 32'h07);
			wb(1'b1, stm_pkg::ADDR_CTRL1, {24'h0, 2'b01, s[1:0], 4'h0});
			wb(1'b1, stm_pkg::ADDR_CTRL0, 32'h08);
			want <= 1'b1;
			repeat (6) @(posedge clk);
			want <= 1'b0;
			repeat (6) @(posedge clk);
			rd(stm_pkg::ADDR_STATUS, (s == 3) ? 32'h0 : 32'h4);
		end
		repeat (2) @(posedge clk);
		chk(exp_q.size(), 32'h0);
		close_out();
	end
endmodule
